// >>> src/cmh_pkg.sv
/*
  cmh_pkg: shared constants and types for the host management port,
  its interface and both ends.
  assumes: one 125 MHz clock, synchronous active-high reset.
*/
package cmh_pkg;
  // host port management modes
  typedef enum logic [2:0] {
    CMH_MODE_BUS16,
    CMH_MODE_BUS8,
    CMH_MODE_SER_MII,
    CMH_MODE_SER_LIGHT,
    CMH_MODE_UNMANAGED
  } cmh_mode_type;

  // host-visible register locations (3-bit address)
  localparam logic [2:0] CMH_LOC_INDEX_LO = 3'h0;
  localparam logic [2:0] CMH_LOC_INDEX_HI = 3'h1;
  localparam logic [2:0] CMH_LOC_VALUE    = 3'h2;
  localparam logic [2:0] CMH_LOC_FRAME    = 3'h3;
  localparam logic [2:0] CMH_LOC_CTRL     = 3'h7;

  // index word layout
  localparam int CMH_IDX_INC_BIT  = 15;
  localparam int CMH_IDX_PAIR_BIT = 14;
  localparam int CMH_IDX_ADDR_W   = 12;

  // configuration space and frame limits
  localparam int CMH_CFG_DEPTH      = 4096;
  localparam int CMH_MIN_PAYLOAD    = 64;
  localparam int CMH_CTRL_MAX_BYTES = 40;

  localparam logic [15:0] CMH_INDEX_RESET = 16'h0000;
  localparam logic [7:0]  CMH_CFG_RESET   = 8'h00;
  localparam logic [15:0] CMH_ZERO16      = 16'h0000;
  localparam logic [7:0]  CMH_ZERO8       = 8'h00;
  localparam logic [3:0]  CMH_ZERO4       = 4'h0;
endpackage

// >>> src/cmh_if.sv
/*
  cmh_if: carrier between the switch end and the host end.
  holds the parallel/serial register bus, the frame-ready line and
  the reverse-mii nibble link. assumes a shared clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface cmh_if;
  import cmh_pkg::*;
  // register access
  logic        acc_valid;
  logic        acc_write;
  logic [2:0]  acc_addr;
  logic [15:0] acc_wdata;
  logic        acc_wide;
  logic [15:0] acc_rdata;
  logic        acc_ack;
  logic        frame_irq;
  // reverse mii: host to switch
  logic        rx_clk_en;
  logic        rx_dv;
  logic [3:0]  rx_d;
  // reverse mii: switch to host
  logic        tx_clk_en;
  logic        tx_en;
  logic [3:0]  tx_d;

  modport dev (
    input  acc_valid, acc_write, acc_addr, acc_wdata, acc_wide, rx_dv, rx_d,
    output acc_rdata, acc_ack, frame_irq, rx_clk_en, tx_clk_en, tx_en, tx_d
  );
  modport host (
    output acc_valid, acc_write, acc_addr, acc_wdata, acc_wide, rx_dv, rx_d,
    input  acc_rdata, acc_ack, frame_irq, rx_clk_en, tx_clk_en, tx_en, tx_d
  );
endinterface
`default_nettype wire

// >>> src/cmh_dev.sv
/*
  cmh_dev: switch end of the host management port. indirect config
  registers, frame register, control frame register, reverse mii.
  assumes: host keeps at most one access in flight; mode is static.
*/
// Notes on behaviour
// [RL1] three management levels: managed, light, unmanaged
// [RL2] 16-bit or 8-bit isa-like parallel bus modes
// [RL3] serial+mii: registers serial, packets over mii
// [RL4] light serial: everything over serial port
// [RL5] unmanaged: config only, no frames, no interrupt
// [RL6] 8-bit registers reached via index and data
// [RL7] 8-bit host writes both index bytes
// [RL8] serial: index at 000b, value at 010b
// [RL9] value location writes/reads selected register
// [RL10] paired flag writes two consecutive registers
// [RL11] index: inc, paired, reserved, 12-bit address
// [RL12] increment flag steps address per access
// [RL13] host sends header bytes then 64+ payload
// [RL14] host frame forwarded like any frame
// [RL15] interrupt while received frame waits
// [RL16] receive header precedes payload bytes
// [RL17] switch drives receive clock as phy
// [RL18] receive clock stops on fifo overflow
// [RL19] host frames data with rx_dv
// [RL20] transmit clock stops on fifo underrun
// [RL21] tx_en spans each frame to host
// [RL22] control frames rejected when unmanaged
// [RL23] control frames via location 111, max 40; code does not count or limit control bytes
// [RL24] 8-bit: 000b low byte, 001b high byte
`timescale 1ns/100ps
`default_nettype none
module cmh_dev
  import cmh_pkg::*;
#(
  parameter int CFG_DEPTH = CMH_CFG_DEPTH
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // mode strap, static
  input  wire cmh_mode_type mode_i,
  // host link
  cmh_if.dev                link,
  // frames to the switch core
  output logic              core_tx_valid_o,
  output logic [7:0]        core_tx_data_o,
  output logic              core_tx_ctrl_o,
  // frames from the switch core
  input  wire logic         core_rx_valid_i,
  input  wire logic [7:0]   core_rx_data_i,
  input  wire logic         core_rx_ctrl_i,
  output logic              core_rx_ready_o,
  // fifo conditions from the mac
  input  wire logic         rx_fifo_overflow_i,
  input  wire logic         tx_fifo_underrun_i,
  // reverse mii from the mac
  input  wire logic         mac_tx_valid_i,
  input  wire logic [3:0]   mac_tx_nibble_i,
  // state readback
  output logic [15:0]       index_o
);
  typedef struct packed {
    logic [15:0] index;
    logic [15:0] rdata;
    logic        ack;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ctrl;
    logic        rx_ready;
    logic [7:0]  rx_hold;
    logic        rx_full;
    logic        rx_ctrl;
    logic        irq;
    logic        rx_clk_en;
    logic        tx_clk_en;
    logic        tx_en;
    logic [3:0]  tx_d;
  } cmh_dev_state_type;

  cmh_dev_state_type st_q, st_d;
  logic [7:0] cfg_q [CFG_DEPTH];

  logic [CMH_IDX_ADDR_W-1:0] addr_cur, addr_next;
  logic managed, frames_on_bus, mii_on, wide_ok, cfg_we, cfg_we_hi;
  logic [7:0] cfg_wd_hi;

  // mode decoding
  assign managed       = (mode_i != CMH_MODE_UNMANAGED); // RL1 RL22
  assign frames_on_bus = (mode_i == CMH_MODE_BUS16) ||
                         (mode_i == CMH_MODE_BUS8) ||
                         (mode_i == CMH_MODE_SER_LIGHT); // RL3 RL4 RL5
  assign mii_on        = (mode_i == CMH_MODE_SER_MII); // RL3
  // paired write is ignored on the byte-wide bus
  assign wide_ok       = (mode_i != CMH_MODE_BUS8); // RL2 RL10
  assign addr_cur      = st_q.index[CMH_IDX_ADDR_W-1:0]; // RL11
  assign addr_next     = addr_cur + 1'b1;

  // config array write strobes, kept outside the state struct
  always_comb begin
    cfg_we    = link.acc_valid && link.acc_write &&
                (link.acc_addr == CMH_LOC_VALUE); // RL6 RL9
    cfg_we_hi = cfg_we && wide_ok && link.acc_wide &&
                st_q.index[CMH_IDX_PAIR_BIT]; // RL10
    cfg_wd_hi = link.acc_wdata[15:8];
  end

  // the config array is large, so it lives in its own process
  always_ff @(posedge clock_i) begin
    if (cfg_we) begin
      cfg_q[addr_cur] <= link.acc_wdata[7:0]; // RL9
    end
    if (cfg_we_hi) begin
      cfg_q[addr_next] <= cfg_wd_hi; // RL10
    end
  end

  // next state
  always_comb begin
    st_d          = st_q;
    st_d.ack      = 1'b0;
    st_d.tx_valid = 1'b0;
    st_d.rx_ready = 1'b0;
    // capture one byte from the core when the hold stage is free
    // with mii only control bytes use the hold, frames take the nibbles
    if (!st_q.rx_full && core_rx_valid_i && managed &&
        (frames_on_bus || core_rx_ctrl_i)) begin // RL3
      st_d.rx_full  = 1'b1;
      st_d.rx_hold  = core_rx_data_i; // RL16
      st_d.rx_ctrl  = core_rx_ctrl_i;
      st_d.rx_ready = 1'b1;
    end
    if (link.acc_valid) begin
      st_d.ack   = 1'b1;
      st_d.rdata = CMH_ZERO16;
      unique case (link.acc_addr)
        CMH_LOC_INDEX_LO: begin
          if (link.acc_write) begin
            if (mode_i == CMH_MODE_BUS8) begin
              st_d.index[7:0] = link.acc_wdata[7:0]; // RL24 RL7
            end else begin
              st_d.index = link.acc_wdata; // RL8 RL11
            end
          end else begin
            st_d.rdata = (mode_i == CMH_MODE_BUS8) ?
                         {CMH_ZERO8, st_q.index[7:0]} : st_q.index;
          end
        end
        CMH_LOC_INDEX_HI: begin
          if (link.acc_write) begin
            st_d.index[15:8] = link.acc_wdata[7:0]; // RL24 RL7
          end else begin
            st_d.rdata = {CMH_ZERO8, st_q.index[15:8]};
          end
        end
        CMH_LOC_VALUE: begin
          if (!link.acc_write) begin
            st_d.rdata = {CMH_ZERO8, cfg_q[addr_cur]}; // RL9
          end
          // step past both bytes after a paired write
          if (st_q.index[CMH_IDX_INC_BIT]) begin
            st_d.index[CMH_IDX_ADDR_W-1:0] = cfg_we_hi ?
              addr_cur + 2'd2 : addr_next; // RL12
          end
        end
        CMH_LOC_FRAME, CMH_LOC_CTRL: begin
          // unmanaged ports swallow frame and control traffic; with mii
          // the control location stays open, frames use the nibble link
          if (managed && (frames_on_bus ||
                          (link.acc_addr == CMH_LOC_CTRL))) begin // RL5 RL22
            if (link.acc_write) begin
              st_d.tx_valid = 1'b1; // RL13 RL14 RL23
              st_d.tx_data  = link.acc_wdata[7:0];
              st_d.tx_ctrl  = (link.acc_addr == CMH_LOC_CTRL);
            end else if (st_q.rx_full &&
                         (st_q.rx_ctrl == (link.acc_addr == CMH_LOC_CTRL))) begin
              st_d.rdata   = {CMH_ZERO8, st_q.rx_hold}; // RL16
              st_d.rx_full = 1'b0;
            end
          end
        end
        default: begin
          st_d.rdata = CMH_ZERO16;
        end
      endcase
    end
    // level interrupt while a received byte waits
    st_d.irq = managed && st_d.rx_full; // RL15
    // reverse mii clocks gated on fifo conditions
    st_d.rx_clk_en = mii_on && !rx_fifo_overflow_i; // RL17 RL18
    st_d.tx_clk_en = mii_on && !tx_fifo_underrun_i; // RL20
    st_d.tx_en     = mii_on && mac_tx_valid_i; // RL21
    st_d.tx_d      = (mii_on && mac_tx_valid_i) ? mac_tx_nibble_i : CMH_ZERO4;
    // mii receive path: a nibble counts only under rx_dv and clock
    if (mii_on && link.rx_dv && st_q.rx_clk_en) begin // RL19
      st_d.tx_valid = 1'b1;
      st_d.tx_data  = {CMH_ZERO4, link.rx_d};
      st_d.tx_ctrl  = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q       <= '0;
      st_q.index <= CMH_INDEX_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign link.acc_rdata = st_q.rdata;
  assign link.acc_ack   = st_q.ack;
  assign link.frame_irq = st_q.irq;
  assign link.rx_clk_en = st_q.rx_clk_en;
  assign link.tx_clk_en = st_q.tx_clk_en;
  assign link.tx_en     = st_q.tx_en;
  assign link.tx_d      = st_q.tx_d;
  assign core_tx_valid_o = st_q.tx_valid;
  assign core_tx_data_o  = st_q.tx_data;
  assign core_tx_ctrl_o  = st_q.tx_ctrl;
  assign core_rx_ready_o = st_q.rx_ready;
  assign index_o         = st_q.index;
endmodule
`default_nettype wire

// >>> src/cmh_host.sv
/*
  cmh_host: host processor end. turns user requests into register
  bus accesses and drives the mii transmit side with rx_dv framing.
  assumes: user waits for done before the next request.
*/
`timescale 1ns/100ps
`default_nettype none
module cmh_host
  import cmh_pkg::*;
(
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // user request
  input  wire logic         req_i,
  input  wire logic         req_write_i,
  input  wire logic [2:0]   req_addr_i,
  input  wire logic [15:0]  req_wdata_i,
  input  wire logic         req_wide_i,
  output logic              busy_o,
  output logic              done_o,
  output logic [15:0]       rdata_o,
  output logic              irq_o,
  // user mii send
  input  wire logic         send_valid_i,
  input  wire logic [3:0]   send_nibble_i,
  // user mii receive
  output logic              recv_valid_o,
  output logic [3:0]        recv_nibble_o,
  // link
  cmh_if.host               link
);
  typedef enum logic [0:0] {
    HS_IDLE,
    HS_WAIT
  } cmh_hstate_type;

  typedef struct packed {
    cmh_hstate_type fsm;
    logic        valid;
    logic        write;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wide;
    logic        done;
    logic [15:0] rdata;
    logic        irq;
    logic        dv;
    logic [3:0]  nib;
    logic        recv_valid;
    logic [3:0]  recv_nib;
    logic        busy;
  } cmh_host_state_type;

  cmh_host_state_type st_q, st_d;

  // request sequencing and mii framing
  always_comb begin
    st_d       = st_q;
    st_d.valid = 1'b0;
    st_d.done  = 1'b0;
    unique case (st_q.fsm)
      HS_IDLE: begin
        if (req_i) begin
          st_d.valid = 1'b1;
          st_d.write = req_write_i;
          st_d.addr  = req_addr_i; // RL7 RL8
          st_d.wdata = req_wdata_i;
          st_d.wide  = req_wide_i; // RL2
          st_d.fsm   = HS_WAIT;
        end
      end
      HS_WAIT: begin
        if (link.acc_ack) begin
          st_d.done  = 1'b1;
          st_d.rdata = link.acc_rdata; // RL16
          st_d.fsm   = HS_IDLE;
        end
      end
    endcase
    st_d.irq = link.frame_irq;
    // only move a nibble while the switch runs our send clock
    if (link.rx_clk_en) begin
      st_d.dv  = send_valid_i; // RL19
      st_d.nib = send_valid_i ? send_nibble_i : CMH_ZERO4;
    end
    // capture only while tx_en and the clock is running
    st_d.recv_valid = link.tx_en && link.tx_clk_en; // RL21
    st_d.recv_nib   = link.tx_d;
    // busy kept in a flop so the output needs no logic after it
    st_d.busy       = (st_d.fsm != HS_IDLE);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_q     <= '0;
      st_q.fsm <= HS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.acc_valid = st_q.valid;
  assign link.acc_write = st_q.write;
  assign link.acc_addr  = st_q.addr;
  assign link.acc_wdata = st_q.wdata;
  assign link.acc_wide  = st_q.wide;
  assign link.rx_dv     = st_q.dv;
  assign link.rx_d      = st_q.nib;
  assign busy_o         = st_q.busy;
  assign done_o         = st_q.done;
  assign rdata_o        = st_q.rdata;
  assign irq_o          = st_q.irq;
  assign recv_valid_o   = st_q.recv_valid;
  assign recv_nibble_o  = st_q.recv_nib;
endmodule
`default_nettype wire

// >>> tb/cmh_props.sv
/*
  cmh_props: concurrent checks on the host link between both ends.
  assumes: instantiated beside the link, one clock, sync reset high.
*/
`timescale 1ns/100ps
`default_nettype none
module cmh_props
  import cmh_pkg::*;
(
  // clock and reset
  input wire logic        clock_i,
  input wire logic        reset_i,
  // register bus
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [2:0]  acc_addr,
  input wire logic [15:0] acc_rdata,
  input wire logic        acc_ack,
  input wire logic        frame_irq
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);

  // a read that frees the one-byte receive hold
  logic frame_rd;
  assign frame_rd = acc_valid && !acc_write &&
                    (acc_addr == CMH_LOC_FRAME || acc_addr == CMH_LOC_CTRL);

  // steps of one access and of a read from a hole in the map
  sequence s_access;
    acc_valid ##1 acc_ack;
  endsequence
  sequence s_hole_read;
    acc_valid && !acc_write && acc_addr inside {3'h4, 3'h5, 3'h6};
  endsequence

  ack_delay_a: assert property (acc_valid |-> s_access)
    else $error("access not acknowledged one cycle later");
  ack_cause_a: assert property (acc_ack |-> $past(acc_valid))
    else $error("acknowledge without a request");
  ack_pulse_a: assert property (acc_ack |=> !acc_ack)
    else $error("acknowledge longer than one cycle");
  one_flight_a: assert property (acc_valid |=> !acc_valid)
    else $error("second access while one is in flight");
  rdata_hold_a: assert property (!acc_ack |-> $stable(acc_rdata))
    else $error("read data moved outside an acknowledge");
  hole_zero_a: assert property (s_hole_read |=> acc_rdata == CMH_ZERO16)
    else $error("read of unmapped location not zero");
  irq_hold_a: assert property (frame_irq && !frame_rd |=> frame_irq)
    else $error("frame interrupt dropped with frame unread");
  irq_release_a: assert property ($fell(frame_irq) |->
    $past(frame_rd, 1) || $past(frame_rd, 2) || $past(frame_rd, 3))
    else $error("frame interrupt dropped without a read");
endmodule
`default_nettype wire

// >>> tb/tb_cpu_mgmt_host_port.sv
/*
  tb_cpu_mgmt_host_port: both ends joined by the link, driven from the
  user side of the host end and the core side of the switch end.
  assumes: mode is only changed while reset is held.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_mgmt_host_port;
  import cmh_pkg::*;
  logic clock_i = 1'b0, reset_i = 1'b1;
  cmh_mode_type mode_i = CMH_MODE_BUS16;
  logic req_i = 1'b0, req_write_i = 1'b0, req_wide_i = 1'b0;
  logic [2:0] req_addr_i = 3'h0;
  logic [15:0] req_wdata_i = 16'h0000, rdata_o, index_o;
  logic busy_o, done_o, irq_o, recv_valid_o, core_tx_valid_o;
  logic core_tx_ctrl_o, core_rx_ready_o;
  logic [3:0] recv_nibble_o, send_nibble_i = 4'h0, mac_tx_nibble_i = 4'h0;
  logic send_valid_i = 1'b0, core_rx_valid_i = 1'b0, core_rx_ctrl_i = 1'b0;
  logic rx_fifo_overflow_i = 1'b0, tx_fifo_underrun_i = 1'b0;
  logic mac_tx_valid_i = 1'b0;
  logic [7:0] core_tx_data_o, core_rx_data_i = 8'h00;
  logic [8:0] tx_last = 9'h000;
  int mismatches = 0, checked = 0, tx_cnt = 0, rdy_cnt = 0;

  cmh_if link ();
  cmh_dev cmh_dev_inst (.clock_i(clock_i), .reset_i(reset_i),
    .mode_i(mode_i), .link(link), .core_tx_valid_o(core_tx_valid_o),
    .core_tx_data_o(core_tx_data_o), .core_tx_ctrl_o(core_tx_ctrl_o),
    .core_rx_valid_i(core_rx_valid_i), .core_rx_data_i(core_rx_data_i),
    .core_rx_ctrl_i(core_rx_ctrl_i), .core_rx_ready_o(core_rx_ready_o),
    .rx_fifo_overflow_i(rx_fifo_overflow_i),
    .tx_fifo_underrun_i(tx_fifo_underrun_i), .mac_tx_valid_i(mac_tx_valid_i),
    .mac_tx_nibble_i(mac_tx_nibble_i), .index_o(index_o));
  cmh_host cmh_host_inst (.clock_i(clock_i), .reset_i(reset_i),
    .req_i(req_i), .req_write_i(req_write_i), .req_addr_i(req_addr_i),
    .req_wdata_i(req_wdata_i), .req_wide_i(req_wide_i), .busy_o(busy_o),
    .done_o(done_o), .rdata_o(rdata_o), .irq_o(irq_o),
    .send_valid_i(send_valid_i), .send_nibble_i(send_nibble_i),
    .recv_valid_o(recv_valid_o), .recv_nibble_o(recv_nibble_o), .link(link));
  cmh_props cmh_props_inst (.clock_i(clock_i), .reset_i(reset_i),
    .acc_valid(link.acc_valid), .acc_write(link.acc_write),
    .acc_addr(link.acc_addr), .acc_rdata(link.acc_rdata),
    .acc_ack(link.acc_ack), .frame_irq(link.frame_irq));

  always #4 clock_i = ~clock_i;
  // bytes handed to the core, sampled before the edge updates them
  always @(posedge clock_i) begin
    if (core_tx_valid_o === 1'b1) begin
      tx_cnt++;
      tx_last <= {core_tx_ctrl_o, core_tx_data_o};
    end
    // bytes the switch end took from the core
    if (core_rx_ready_o === 1'b1) begin
      rdy_cnt++;
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one access: request for one cycle, then wait for done at negedges
  task automatic acc(input logic w, input logic [2:0] a,
                     input logic [15:0] d, input logic wd,
                     output logic [15:0] r);
    int n;
    n = 0;
    @(posedge clock_i);
    req_i <= 1'b1; req_write_i <= w; req_addr_i <= a;
    req_wdata_i <= d; req_wide_i <= wd;
    @(posedge clock_i);
    req_i <= 1'b0;
    @(negedge clock_i);
    chk("busy", 16'h0001, {15'h0000, busy_o});
    while (done_o !== 1'b1 && n < 20) begin @(negedge clock_i); n++; end
    r = rdata_o;
    chk("done", 16'h0001, {15'h0000, done_o});
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d, input logic wd);
    logic [15:0] r;
    acc(1'b1, a, d, wd, r);
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] r);
    acc(1'b0, a, 16'h0000, 1'b0, r);
  endtask
  // mode strap only moves under reset
  task automatic do_reset(input cmh_mode_type m);
    @(posedge clock_i);
    reset_i <= 1'b1; mode_i <= m;
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
  endtask

  task automatic t_cfg16;
    logic [15:0] r;
    do_reset(CMH_MODE_BUS16);
    wr(CMH_LOC_INDEX_LO, 16'h0005, 1'b1);
    wr(CMH_LOC_VALUE, 16'h00a5, 1'b0);
    rd(CMH_LOC_VALUE, r);
    chk("cfg 005", 16'h00a5, {8'h00, r[7:0]});
    wr(CMH_LOC_INDEX_LO, 16'hc010, 1'b1);
    chk("index", 16'hc010, index_o);
    wr(CMH_LOC_VALUE, 16'h2211, 1'b1);
    chk("index pair step", 16'hc012, index_o);
    wr(CMH_LOC_INDEX_LO, 16'h8010, 1'b1);
    rd(CMH_LOC_VALUE, r);
    chk("cfg 010", 16'h0011, {8'h00, r[7:0]});
    rd(CMH_LOC_VALUE, r);
    chk("cfg 011", 16'h0022, {8'h00, r[7:0]});
    chk("index step", 16'h8012, index_o);
    rd(3'h5, r);
    chk("unmapped", 16'h0000, r);
  endtask

  // pairing flag is ignored on the byte bus
  task automatic t_cfg8;
    logic [15:0] r;
    do_reset(CMH_MODE_BUS8);
    wr(CMH_LOC_INDEX_LO, 16'h0021, 1'b0);
    wr(CMH_LOC_INDEX_HI, 16'h0000, 1'b0);
    wr(CMH_LOC_VALUE, 16'h0099, 1'b0);
    wr(CMH_LOC_INDEX_LO, 16'h0020, 1'b0);
    wr(CMH_LOC_INDEX_HI, 16'h0040, 1'b0);
    chk("index bytes", 16'h4020, index_o);
    wr(CMH_LOC_VALUE, 16'h3377, 1'b1);
    rd(CMH_LOC_VALUE, r);
    chk("cfg 020", 16'h0077, {8'h00, r[7:0]});
    wr(CMH_LOC_INDEX_LO, 16'h0021, 1'b0);
    wr(CMH_LOC_INDEX_HI, 16'h0000, 1'b0);
    rd(CMH_LOC_VALUE, r);
    chk("cfg 021", 16'h0099, {8'h00, r[7:0]});
  endtask

  task automatic t_frame;
    logic [15:0] r;
    int n, c;
    do_reset(CMH_MODE_BUS16);
    rd(CMH_LOC_FRAME, r);
    chk("empty frame", 16'h0000, r);
    c = rdy_cnt;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      @(posedge clock_i);
      core_rx_valid_i <= 1'b1; core_rx_ctrl_i <= (k == 1);
      core_rx_data_i <= (k == 1) ? 8'h66 : 8'h5a;
      while (irq_o !== 1'b1 && n < 20) begin @(negedge clock_i); n++; end
      @(posedge clock_i);
      core_rx_valid_i <= 1'b0;
      chk("irq", 16'h0001, {15'h0000, irq_o});
      rd((k == 1) ? CMH_LOC_CTRL : CMH_LOC_FRAME, r);
      chk("rx byte", (k == 1) ? 16'h0066 : 16'h005a, {8'h00, r[7:0]});
      repeat (3) @(negedge clock_i);
      chk("irq clear", 16'h0000, {15'h0000, irq_o});
    end
    chk("core taken", 16'h0002, 16'(rdy_cnt - c));
    // header bytes then the shortest legal payload, one byte per write
    c = tx_cnt;
    for (int b = 0; b < 3 + CMH_MIN_PAYLOAD; b++) begin
      wr(CMH_LOC_FRAME, 16'(b), 1'b0);
    end
    repeat (3) @(negedge clock_i);
    chk("frame bytes", 16'(3 + CMH_MIN_PAYLOAD), 16'(tx_cnt - c));
    wr(CMH_LOC_FRAME, 16'h0033, 1'b0);
    repeat (3) @(negedge clock_i);
    chk("tx frame byte", 16'h0033, {7'h00, tx_last});
    wr(CMH_LOC_CTRL, 16'h0044, 1'b0);
    repeat (3) @(negedge clock_i);
    chk("tx ctrl byte", 16'h0144, {7'h00, tx_last});
  endtask

  // which modes carry frames over the register bus, and the mii clock
  task automatic t_modes;
    cmh_mode_type md [5];
    int inc [5];
    int c;
    md = '{CMH_MODE_BUS16, CMH_MODE_BUS8, CMH_MODE_SER_MII,
           CMH_MODE_SER_LIGHT, CMH_MODE_UNMANAGED};
    // with mii only the control byte goes over the register bus
    inc = '{2, 2, 1, 2, 0};
    for (int k = 0; k < 5; k++) begin
      do_reset(md[k]);
      c = tx_cnt;
      wr(CMH_LOC_FRAME, 16'h0033, 1'b0);
      wr(CMH_LOC_CTRL, 16'h0044, 1'b0);
      repeat (3) @(negedge clock_i);
      chk("bytes out", 16'(inc[k]), 16'(tx_cnt - c));
      chk("rx clock", {15'h0000, md[k] == CMH_MODE_SER_MII},
          {15'h0000, link.rx_clk_en});
    end
  endtask

  task automatic t_unmgd;
    logic [15:0] r;
    do_reset(CMH_MODE_UNMANAGED);
    wr(CMH_LOC_INDEX_LO, 16'h0007, 1'b1);
    wr(CMH_LOC_VALUE, 16'h005c, 1'b0);
    rd(CMH_LOC_VALUE, r);
    chk("cfg 007", 16'h005c, {8'h00, r[7:0]});
    @(posedge clock_i);
    core_rx_valid_i <= 1'b1; core_rx_ctrl_i <= 1'b1; core_rx_data_i <= 8'h5a;
    repeat (4) @(posedge clock_i);
    core_rx_valid_i <= 1'b0;
    @(negedge clock_i);
    chk("irq off", 16'h0000, {15'h0000, irq_o});
    rd(CMH_LOC_CTRL, r);
    chk("ctrl refused", 16'h0000, r);
  endtask

  task automatic t_mii;
    int n;
    do_reset(CMH_MODE_SER_MII);
    for (int k = 0; k < 3; k++) begin
      @(posedge clock_i);
      rx_fifo_overflow_i <= (k == 0); tx_fifo_underrun_i <= (k == 1);
      repeat (3) @(negedge clock_i);
      chk("rx clock", {15'h0000, k != 0}, {15'h0000, link.rx_clk_en});
      chk("tx clock", {15'h0000, k != 1}, {15'h0000, link.tx_clk_en});
    end
    n = 0;
    @(posedge clock_i);
    mac_tx_valid_i <= 1'b1; mac_tx_nibble_i <= 4'h9;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("tx_en", 16'h0001, {15'h0000, link.tx_en});
    chk("tx_d", 16'h0009, {12'h000, link.tx_d});
    while (recv_valid_o !== 1'b1 && n < 20) begin @(negedge clock_i); n++; end
    chk("recv nibble", 16'h0009, {12'h000, recv_nibble_o});
    @(posedge clock_i);
    mac_tx_valid_i <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    chk("tx_en end", 16'h0000, {15'h0000, link.tx_en});
    n = 0;
    @(posedge clock_i);
    send_valid_i <= 1'b1; send_nibble_i <= 4'h6;
    while (link.rx_dv !== 1'b1 && n < 20) begin @(negedge clock_i); n++; end
    chk("rx_d", 16'h0006, {12'h000, link.rx_d});
    @(posedge clock_i);
    send_valid_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    chk("rx_dv end", 16'h0000, {15'h0000, link.rx_dv});
    chk("mii nibble", 16'h0006, {7'h00, tx_last});
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // the whole run is a few hundred cycles
  initial begin
    #200000;
    mismatches++;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clock_i);
    reset_i <= 1'b0;
    t_cfg16;
    t_cfg8;
    t_frame;
    t_modes;
    t_unmgd;
    t_mii;
    final_report;
  end
endmodule
`default_nettype wire
